// >>> discrepancy_channel.sv
// two-channel fail-safe input evaluation with tolerance timing and latch
`include "safe_speed_defs.svh"
`timescale 1ns/1ps
module discrepancy_channel #(
	parameter int TOL_CYCLES = `TOL_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic ch_a_i,
	input wire logic ch_b_i,
	input wire logic ack_i,
	output logic value_o,
	output logic alarm_o
);
	localparam int CW = $clog2(TOL_CYCLES + 1);
	initial begin
		if (TOL_CYCLES < 1) $error("tolerance must be at least one cycle");
	end
	logic [1:0] sync_a;
	logic [1:0] sync_b;
	logic [CW-1:0] cnt;
	logic latched;
	logic [CW-1:0] next_cnt;
	logic next_latched;
	logic next_value;
	logic disagree;
	always_comb begin
		disagree = sync_a[1] ^ sync_b[1];
		next_cnt = '0;
		next_latched = latched;
		if (disagree && !latched) begin
			if (cnt == CW'(TOL_CYCLES - 1)) begin
				next_latched = 1'b1;
			end else begin
				next_cnt = cnt + CW'(1);
			end
		end
		if (ack_i && !disagree) begin
			next_latched = 1'b0;
		end
		// a latched or still-disagreeing input evaluates safe
		next_value = (latched || next_latched || disagree) ? 1'b0 : sync_a[1];
	end
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			sync_a <= 2'h0;
			sync_b <= 2'h0;
			cnt <= '0;
			latched <= 1'b0;
			value_o <= 1'b0;
			alarm_o <= 1'b0;
		end else begin
			sync_a <= {sync_a[0], ch_a_i};
			sync_b <= {sync_b[0], ch_b_i};
			cnt <= next_cnt;
			latched <= next_latched;
			value_o <= next_value;
			alarm_o <= next_latched;
		end
	end
endmodule : discrepancy_channel

// >>> failsafe_pair_model.sv
// two-channel fail-safe input as the safety controller drives it
`timescale 1ns/1ps
module failsafe_pair_model (
	input wire logic clk_sys_i,
	input wire logic level_i,
	input wire logic split_i,
	output logic ch_a_o = 1'b0,
	output logic ch_b_o = 1'b0
);
	// channel b departs only when a discrepancy is ordered
	always @(posedge clk_sys_i) begin
		ch_a_o <= level_i;
		ch_b_o <= split_i ? ~level_i : level_i;
	end
endmodule : failsafe_pair_model

// >>> pulse_ack_detect.sv
// detects a 0-1-0 (or inverted 1-0-1) pulse on one line
`timescale 1ns/1ps
module pulse_ack_detect #(
	parameter bit IDLE_LEVEL = 1'b0
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic level_i,
	output logic pulse_o
);
	logic armed;
	logic prev;
	logic next_armed;
	logic next_prev;
	always_comb begin
		next_prev = level_i;
		next_armed = armed;
		pulse_o = 1'b0;
		if (prev == IDLE_LEVEL && level_i != IDLE_LEVEL) begin
			next_armed = 1'b1;
		end else if (armed && prev != IDLE_LEVEL && level_i == IDLE_LEVEL) begin
			next_armed = 1'b0;
			pulse_o = 1'b1;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			armed <= 1'b0;
			prev <= IDLE_LEVEL;
		end else begin
			armed <= next_armed;
			prev <= next_prev;
		end
	end
endmodule : pulse_ack_detect

// >>> safe_speed_defs.svh
// timing and reset constants for the safe speed fault handler
// Operation
// - input discrepancy under limited speed stays inside that function, no error flag.
// - safety error bit stays cleared on such a discrepancy.
// - discrepancy alarm raised only after the tolerance time expires.
// - after the alarm, limited speed stays active and the motor keeps running.
// - discrepant input evaluates to zero until fail-safe acknowledge or power cycle.
// - torque-off or controlled-stop pulse 1-0-1 also acknowledges, and stops the drive.
// - speed violation under limited speed triggers configured immediate or ramped stop.
// - internal event acknowledged by 0-1-0 on control word bit 7 or input.
// - 1-0-1 on torque-off bit 0 or controlled-stop bit 1 also acknowledges.
// - speed threshold monitor has no external select input.
// - threshold monitor active only if extended functions enabled and limit above zero.
// - speed-below-limit flag is zero after power-up.
// - with motor on, flag shows whether load speed is below the limit.
// - inactive threshold monitor imposes no run command conditions.
// - no run within 5 s: return to torque-off, ignore run, raise alarm.
`ifndef SAFE_SPEED_DEFS_SVH
`define SAFE_SPEED_DEFS_SVH
`define CLK_PERIOD_NS 10
`define RUN_WINDOW_MS 5000
`define RUN_WINDOW_CYCLES (`RUN_WINDOW_MS * (1000000 / `CLK_PERIOD_NS))
`define TOL_TIME_US 500
`define TOL_CYCLES ((`TOL_TIME_US * 1000) / `CLK_PERIOD_NS)
`define RAMP_TIME_US 1000
`define RAMP_CYCLES ((`RAMP_TIME_US * 1000) / `CLK_PERIOD_NS)
`define SPEED_FLAG_RESET 1'b0
`define CW_TORQUE_OFF_BIT 0
`define CW_CTRL_STOP_BIT 1
`define CW_ACK_BIT 7
`endif

// >>> safe_speed_fault_handler.sv
// limited speed fault handling, stop responses and speed threshold monitor
`include "safe_speed_defs.svh"
`timescale 1ns/1ps
module safe_speed_fault_handler
	import safe_speed_pkg::*;
#(
	parameter int SPEED_W = 16,
	parameter int TOL_CYCLES = `TOL_CYCLES,
	parameter int RAMP_CYCLES = `RAMP_CYCLES,
	parameter int RUN_WINDOW_CYCLES = `RUN_WINDOW_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] control_word_i,
	input wire logic ack_in_a_i,
	input wire logic ack_in_b_i,
	input wire logic lsd_in_a_i,
	input wire logic lsd_in_b_i,
	input wire logic run_command_i,
	input wire logic standard_ack_i,
	input wire logic ext_functions_en_i,
	input wire logic ramped_stop_cfg_i,
	input wire logic [SPEED_W-1:0] load_speed_i,
	input wire logic [SPEED_W-1:0] limit_speed_i,
	input wire logic [SPEED_W-1:0] monitor_speed_i,
	input wire logic speed_violation_i,
	output logic limited_speed_active_flag_o,
	output logic internal_event_flag_o,
	output logic safety_error_o,
	output logic discrepancy_alarm_o,
	output logic torque_off_active_flag_o,
	output logic ramp_stop_o,
	output logic run_enable_o,
	output logic run_timeout_alarm_o,
	output logic speed_threshold_active_o,
	output logic speed_below_limit_flag_o
);
	localparam int RCW = $clog2(RAMP_CYCLES + 1);
	localparam int WCW = $clog2(RUN_WINDOW_CYCLES + 1);
	initial begin
		if (SPEED_W < 2) $error("speed width too small");
		if (RAMP_CYCLES < 1 || RUN_WINDOW_CYCLES < 1) $error("timing counts must be positive");
		if (TOL_CYCLES < 1) $error("tolerance must be at least one cycle");
	end

	logic [2:0] cw_s1;
	logic [2:0] cw_s2;
	logic run_s1;
	logic run_s2;
	logic sack_s1;
	logic sack_s2;

	// control word bits, run command and standard ack come from outside this clock: two stages each
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			cw_s1 <= 3'h3;
			cw_s2 <= 3'h3;
			run_s1 <= 1'b0;
			run_s2 <= 1'b0;
			sack_s1 <= 1'b0;
			sack_s2 <= 1'b0;
		end else begin
			cw_s1 <= {control_word_i[`CW_ACK_BIT], control_word_i[`CW_CTRL_STOP_BIT],
				control_word_i[`CW_TORQUE_OFF_BIT]};
			cw_s2 <= cw_s1;
			run_s1 <= run_command_i;
			run_s2 <= run_s1;
			sack_s1 <= standard_ack_i;
			sack_s2 <= sack_s1;
		end
	end

	logic ack_pin_value;
	logic lsd_value;
	logic ack_disc_alarm;
	logic lsd_disc_alarm;
	logic fs_ack;
	logic [2:0] ack_pulse;
	logic failsafe_ack_pulse;
	logic torque_off_pulse;
	logic ctrl_stop_pulse;
	logic any_ack;
	logic stop_ack;

	// channel synchronisers live inside each channel
	discrepancy_channel #(.TOL_CYCLES(TOL_CYCLES)) u_ack_ch (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.ch_a_i(ack_in_a_i),
		.ch_b_i(ack_in_b_i),
		.ack_i(fs_ack),
		.value_o(ack_pin_value),
		.alarm_o(ack_disc_alarm)
	);
	discrepancy_channel #(.TOL_CYCLES(TOL_CYCLES)) u_lsd_ch (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.ch_a_i(lsd_in_a_i),
		.ch_b_i(lsd_in_b_i),
		.ack_i(fs_ack),
		.value_o(lsd_value),
		.alarm_o(lsd_disc_alarm)
	);

	logic [2:0] ack_src;
	assign ack_src = {cw_s2[2] | ack_pin_value, cw_s2[1], cw_s2[0]};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_ack
			pulse_ack_detect #(.IDLE_LEVEL(gi == 2 ? 1'b0 : 1'b1)) u_det (
				.clk_sys_i(clk_sys_i),
				.sys_rst_i(sys_rst_i),
				.level_i(ack_src[gi]),
				.pulse_o(ack_pulse[gi])
			);
		end
	endgenerate

	assign failsafe_ack_pulse = ack_pulse[2];
	assign torque_off_pulse = ack_pulse[0];
	assign ctrl_stop_pulse = ack_pulse[1];
	assign stop_ack = torque_off_pulse | ctrl_stop_pulse;
	assign any_ack = failsafe_ack_pulse | stop_ack;
	assign fs_ack = any_ack;

	// limited speed runs while not deselected; the discrepant input reads zero
	logic lsd_active;
	assign lsd_active = !lsd_value;
	// discrepancy never feeds the error bit: it is not an internal event
	assign safety_error_o = internal_event_flag_o;

	drive_state_e state;
	drive_state_e next_state;
	logic [RCW-1:0] ramp_cnt;
	logic [RCW-1:0] next_ramp_cnt;
	logic [WCW-1:0] win_cnt;
	logic [WCW-1:0] next_win_cnt;
	logic win_open;
	logic next_win_open;
	logic event_flag;
	logic next_event_flag;
	logic ack_pending;
	logic next_ack_pending;
	logic timeout;
	logic next_timeout;
	logic to_sel_prev;
	logic to_sel_now;

	// either selection bit low asks for torque off
	function automatic logic stop_selected(input logic [2:0] sel);
		return !sel[0] || !sel[1];
	endfunction : stop_selected

	assign to_sel_now = stop_selected(cw_s2);

	always_comb begin
		next_state = state;
		next_ramp_cnt = ramp_cnt;
		next_win_cnt = win_cnt;
		next_win_open = win_open;
		next_event_flag = event_flag;
		next_ack_pending = ack_pending;
		next_timeout = timeout;
		if (any_ack && event_flag) begin
			next_ack_pending = 1'b1;
		end
		if (ack_pending && sack_s2 && !run_s2) begin
			next_event_flag = 1'b0;
			next_ack_pending = 1'b0;
		end
		// violation wins over a clearing acknowledgment in the same cycle
		if (speed_violation_i && lsd_active) begin
			next_event_flag = 1'b1;
			next_ack_pending = 1'b0;
		end
		unique case (state)
			DRV_RUN: begin
				if (speed_violation_i && lsd_active) begin
					if (ramped_stop_cfg_i) begin
						next_state = DRV_RAMP;
						next_ramp_cnt = '0;
					end else begin
						next_state = DRV_TORQUE_OFF;
					end
				end else if (stop_ack || to_sel_now) begin
					next_state = DRV_TORQUE_OFF;
				end
			end
			DRV_RAMP: begin
				if (ramp_cnt == RCW'(RAMP_CYCLES - 1)) begin
					next_state = DRV_TORQUE_OFF;
				end else begin
					next_ramp_cnt = ramp_cnt + RCW'(1);
				end
			end
			DRV_TORQUE_OFF: begin
				if (!next_event_flag && !to_sel_now && run_s2 && win_open) begin
					next_state = DRV_RUN;
					next_win_open = 1'b0;
				end
			end
			default: begin
				next_state = DRV_TORQUE_OFF;
			end
		endcase
		// run window opens when torque-off selection is released
		if (state == DRV_TORQUE_OFF && to_sel_prev && !to_sel_now) begin
			next_win_open = 1'b1;
			next_win_cnt = '0;
			next_timeout = 1'b0;
		end else if (win_open && next_state == DRV_TORQUE_OFF) begin
			if (win_cnt == WCW'(RUN_WINDOW_CYCLES - 1)) begin
				next_win_open = 1'b0;
				next_timeout = 1'b1;
			end else begin
				next_win_cnt = win_cnt + WCW'(1);
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			state <= DRV_TORQUE_OFF;
			ramp_cnt <= '0;
			win_cnt <= '0;
			win_open <= 1'b0;
			event_flag <= 1'b0;
			ack_pending <= 1'b0;
			timeout <= 1'b0;
			// idle is deselected, so leaving reset opens no run window
			to_sel_prev <= 1'b0;
		end else begin
			state <= next_state;
			ramp_cnt <= next_ramp_cnt;
			win_cnt <= next_win_cnt;
			win_open <= next_win_open;
			event_flag <= next_event_flag;
			ack_pending <= next_ack_pending;
			timeout <= next_timeout;
			to_sel_prev <= to_sel_now;
		end
	end

	// speed threshold monitor: configuration only, no select input
	logic ssm_active;
	logic speed_below;
	logic next_speed_below;
	assign ssm_active = ext_functions_en_i && (monitor_speed_i != '0);

	always_comb begin
		next_speed_below = speed_below;
		if (!ssm_active) begin
			next_speed_below = `SPEED_FLAG_RESET;
		end else if (state == DRV_RUN) begin
			next_speed_below = load_speed_i < monitor_speed_i;
		end
	end

	logic next_limited_active;
	logic next_torque_off;
	logic next_ramp_stop;
	logic next_run_enable;
	logic next_thr_active;
	logic next_disc_alarm;

	// state flags decode the next state so they change together with it; the others register their sources
	always_comb begin
		// discrepancy alone keeps limited speed and the drive running
		next_limited_active = lsd_active;
		next_torque_off = next_state == DRV_TORQUE_OFF;
		next_ramp_stop = next_state == DRV_RAMP;
		// threshold monitor state never gates run enable
		next_run_enable = next_state == DRV_RUN;
		next_thr_active = ssm_active;
		next_disc_alarm = ack_disc_alarm | lsd_disc_alarm;
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			speed_below <= `SPEED_FLAG_RESET;
			limited_speed_active_flag_o <= 1'b0;
			internal_event_flag_o <= 1'b0;
			discrepancy_alarm_o <= 1'b0;
			torque_off_active_flag_o <= 1'b1;
			ramp_stop_o <= 1'b0;
			run_enable_o <= 1'b0;
			run_timeout_alarm_o <= 1'b0;
			speed_threshold_active_o <= 1'b0;
		end else begin
			speed_below <= next_speed_below;
			limited_speed_active_flag_o <= next_limited_active;
			internal_event_flag_o <= next_event_flag;
			discrepancy_alarm_o <= next_disc_alarm;
			torque_off_active_flag_o <= next_torque_off;
			ramp_stop_o <= next_ramp_stop;
			run_enable_o <= next_run_enable;
			run_timeout_alarm_o <= next_timeout;
			speed_threshold_active_o <= next_thr_active;
		end
	end
	assign speed_below_limit_flag_o = speed_below;
	// limit_speed_i is the violation reference for the external motion monitor
	logic unused_limit;
	assign unused_limit = ^limit_speed_i;
endmodule : safe_speed_fault_handler

// >>> safe_speed_fault_handler_monitor.sv
// port assertions for the safe speed fault handler
`timescale 1ns/1ps
module safe_speed_monitor #(
	parameter int SPEED_W = 16,
	parameter int TOL_CYCLES = 8,
	parameter int RAMP_CYCLES = 8
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] control_word_i,
	input wire logic ack_in_a_i,
	input wire logic ack_in_b_i,
	input wire logic lsd_in_a_i,
	input wire logic lsd_in_b_i,
	input wire logic ext_functions_en_i,
	input wire logic ramped_stop_cfg_i,
	input wire logic [SPEED_W-1:0] monitor_speed_i,
	input wire logic speed_violation_i,
	input wire logic limited_speed_active_flag_o,
	input wire logic internal_event_flag_o,
	input wire logic safety_error_o,
	input wire logic discrepancy_alarm_o,
	input wire logic torque_off_active_flag_o,
	input wire logic ramp_stop_o,
	input wire logic run_enable_o,
	input wire logic speed_threshold_active_o,
	input wire logic speed_below_limit_flag_o
);
	localparam int RAMP_MAX = RAMP_CYCLES + 4;
	int run_len;
	int next_run_len;
	int longest;
	int next_longest;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	// longest disagreement since reset; merged pairs only overestimate
	always_comb begin
		next_run_len = (lsd_in_a_i != lsd_in_b_i || ack_in_a_i != ack_in_b_i) ? run_len + 1 : 0;
		next_longest = (next_run_len > longest) ? next_run_len : longest;
	end
	always_ff @(posedge clk_sys_i) begin
		run_len <= sys_rst_i ? 0 : next_run_len;
		longest <= sys_rst_i ? 0 : next_longest;
	end
	sequence s_violation;
		speed_violation_i && limited_speed_active_flag_o && run_enable_o;
	endsequence
	sequence s_stop_taken;
		internal_event_flag_o && (ramped_stop_cfg_i ? ramp_stop_o : torque_off_active_flag_o);
	endsequence
	chk_error_mirror: assert property ($rose(safety_error_o) |-> $past(speed_violation_i))
		else $error("safety error raised without a speed violation");
	chk_reset_state: assert property (@(posedge clk_sys_i) disable iff (1'b0)
		$fell(sys_rst_i) |-> torque_off_active_flag_o && !speed_below_limit_flag_o && !internal_event_flag_o)
		else $error("wrong state after reset");
	chk_thr_active: assert property ((ext_functions_en_i && monitor_speed_i != '0) [*3]
		|-> speed_threshold_active_o) else $error("threshold monitor not active");
	chk_thr_idle: assert property ((!ext_functions_en_i || monitor_speed_i == '0) [*3]
		|-> !speed_threshold_active_o && !speed_below_limit_flag_o) else $error("threshold monitor not idle");
	chk_violation_stop: assert property (s_violation |-> ##[1:2] s_stop_taken)
		else $error("violation did not stop drive");
	chk_ramp_ends_off: assert property ($rose(ramp_stop_o) |-> ##[1:RAMP_MAX] torque_off_active_flag_o)
		else $error("ramp did not end in torque off");
	chk_disc_keeps_run: assert property ($rose(discrepancy_alarm_o) && run_enable_o && !speed_violation_i
		&& control_word_i[1:0] == 2'b11 |=> run_enable_o && !safety_error_o) else $error("discrepancy stopped drive");
	chk_alarm_after_tol: assert property ($rose(discrepancy_alarm_o) |-> longest >= TOL_CYCLES - 1)
		else $error("discrepancy alarm too early");
	chk_select_stops: assert property (!control_word_i[0] [*5] |-> !run_enable_o)
		else $error("torque off selection ignored");
endmodule : safe_speed_monitor
bind safe_speed_fault_handler safe_speed_monitor #(.SPEED_W(SPEED_W), .TOL_CYCLES(TOL_CYCLES),
	.RAMP_CYCLES(RAMP_CYCLES)) u_safe_speed_monitor (.*);

// >>> safe_speed_pkg.sv
// types for the safe speed fault handler
package safe_speed_pkg;
	typedef enum logic [1:0] {
		STOP_IMMEDIATE,
		STOP_RAMPED
	} stop_cat_e;
	typedef enum logic [1:0] {
		DRV_RUN,
		DRV_RAMP,
		DRV_TORQUE_OFF
	} drive_state_e;
endpackage : safe_speed_pkg

// >>> testbench.sv
// self-checking bench for the safe speed fault handler
`timescale 1ns/1ps
module testbench;
	localparam int TOL = 8;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [7:0] cw = 8'h03;
	logic lsd_lvl = 1'b0, lsd_split = 1'b0, ack_lvl = 1'b0, ack_split = 1'b0;
	logic run = 1'b0, sack = 1'b0, ext_en = 1'b0, ramp_cfg = 1'b0, viol = 1'b0;
	logic [15:0] load = 16'h0000, mon = 16'h0000;
	logic lsd_a, lsd_b, ack_a, ack_b, lsa, evt, err, alm, toff, ramp, run_en, tmo, thr, below;
	int errors = 0, samples_checked = 0;
	always #5 clk_sys_i = ~clk_sys_i;
	failsafe_pair_model u_failsafe_pair_model (.clk_sys_i(clk_sys_i), .level_i(lsd_lvl), .split_i(lsd_split),
		.ch_a_o(lsd_a), .ch_b_o(lsd_b));
	failsafe_pair_model u_failsafe_pair_model_ack (.clk_sys_i(clk_sys_i), .level_i(ack_lvl), .split_i(ack_split),
		.ch_a_o(ack_a), .ch_b_o(ack_b));
	safe_speed_fault_handler #(.TOL_CYCLES(TOL), .RAMP_CYCLES(8), .RUN_WINDOW_CYCLES(50)) u_safe_speed_fault_handler (
		.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .control_word_i(cw), .ack_in_a_i(ack_a), .ack_in_b_i(ack_b),
		.lsd_in_a_i(lsd_a), .lsd_in_b_i(lsd_b), .run_command_i(run), .standard_ack_i(sack), .ext_functions_en_i(ext_en),
		.ramped_stop_cfg_i(ramp_cfg), .load_speed_i(load), .limit_speed_i(16'h0000), .monitor_speed_i(mon),
		.speed_violation_i(viol), .limited_speed_active_flag_o(lsa), .internal_event_flag_o(evt), .safety_error_o(err),
		.discrepancy_alarm_o(alm), .torque_off_active_flag_o(toff), .ramp_stop_o(ramp), .run_enable_o(run_en),
		.run_timeout_alarm_o(tmo), .speed_threshold_active_o(thr), .speed_below_limit_flag_o(below));
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : tick
	task automatic cmp(input string name, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %b seen %b", name, exp, got);
		end
	endtask : cmp
	// pulse kinds: 0-7 control word bit to lvl and back, 8 ack pins, 9 standard ack
	task automatic pulse(input int b, input logic lvl);
		if (b == 8) ack_lvl <= lvl;
		else if (b == 9) sack <= lvl;
		else cw[b] <= lvl;
		tick(4);
		if (b == 8) ack_lvl <= ~lvl;
		else if (b == 9) sack <= ~lvl;
		else cw[b] <= ~lvl;
		tick(4);
	endtask : pulse
	task automatic start_drive();
		pulse(0, 1'b0);
		run <= 1'b1;
		tick(10);
		cmp("run_enable", 1'b1, run_en);
	endtask : start_drive
	task automatic close_out();
		if (errors == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : close_out
	initial begin
		#300000;
		errors++;
		close_out();
	end
	initial begin
		tick(20);
		sys_rst_i <= 1'b0;
		tick(2);
		cmp("torque_off", 1'b1, toff);
		cmp("below_flag", 1'b0, below);
		ext_en <= 1'b1;
		mon <= 16'h0064;
		load <= 16'h0032;
		start_drive();
		cmp("thr_active", 1'b1, thr);
		cmp("below_flag", 1'b1, below);
		load <= 16'h00c8;
		tick(4);
		cmp("below_flag", 1'b0, below);
		lsd_split <= 1'b1;
		tick(TOL - 4);
		lsd_split <= 1'b0;
		tick(TOL);
		cmp("disc_alarm", 1'b0, alm);
		lsd_split <= 1'b1;
		tick(TOL + 6);
		cmp("disc_alarm", 1'b1, alm);
		cmp("safety_error", 1'b0, err);
		cmp("run_enable", 1'b1, run_en);
		lsd_split <= 1'b0;
		lsd_lvl <= 1'b1;
		tick(6);
		cmp("limited_active", 1'b1, lsa);
		pulse(8, 1'b1);
		pulse(9, 1'b1);
		cmp("disc_alarm", 1'b0, alm);
		cmp("limited_active", 1'b0, lsa);
		lsd_lvl <= 1'b0;
		tick(6);
		for (int k = 0; k < 4; k++) begin
			ramp_cfg <= k[0];
			viol <= 1'b1;
			tick(3);
			viol <= 1'b0;
			cmp("event", 1'b1, evt);
			cmp("ramp_stop", k[0], ramp);
			tick(12);
			cmp("torque_off", 1'b1, toff);
			run <= 1'b0;
			tick(4);
			pulse((k == 0) ? 7 : (k == 1) ? 8 : k - 2, (k < 2) ? 1'b1 : 1'b0);
			pulse(9, 1'b1);
			cmp("event", 1'b0, evt);
			start_drive();
		end
		run <= 1'b0;
		cw[0] <= 1'b0;
		tick(8);
		cmp("run_enable", 1'b0, run_en);
		cw[0] <= 1'b1;
		tick(60);
		cmp("run_timeout", 1'b1, tmo);
		run <= 1'b1;
		tick(10);
		cmp("run_enable", 1'b0, run_en);
		start_drive();
		mon <= 16'h0000;
		tick(6);
		cmp("thr_active", 1'b0, thr);
		cmp("below_flag", 1'b0, below);
		close_out();
	end
endmodule : testbench
